/* rtl/mlpd_pkg.sv */
// Shared constants, types and helpers of the memory LUT predistorter
`default_nettype none
package mlpd_pkg;
  localparam int NUM_ANT   = 4;
  localparam int DW        = 16;
  localparam int CW        = 16;
  localparam int IDX_W     = 3;
  localparam int FRAC_W    = 4;
  localparam int QW        = IDX_W + FRAC_W;
  localparam int DEPTH     = 1 << IDX_W;
  localparam int SLOTS     = 36;
  localparam int TAPS_2ANT = 36;
  localparam int TAPS_4ANT = 18;
  localparam int ANT_2MODE = 2;
  localparam int COEF_FRAC = 14;
  localparam int ACC_W     = DW + CW + 6;
  localparam logic signed [CW-1:0] COEF_UNITY = 16'sh4000;
  localparam logic RST_ANT4 = 1'b1;
  // Configuration bus of the engine
  localparam int AW = 16;
  localparam logic [AW-1:0] ADDR_CTRL = 16'h0000;
  localparam logic [AW-1:0] ADDR_SYNC = 16'h0001;
  localparam int A_COEF   = 15;
  localparam int A_ANT    = 12;
  localparam int ANT_W    = 2;
  localparam int A_SLOT   = 6;
  localparam int SLOT_W   = 6;
  localparam int A_ENT    = 0;
  localparam int ENT_W    = 6;
  // Control word fields
  localparam int C_MAGSQ  = 0;
  localparam int C_ANT4   = 1;
  localparam int C_SETS   = 2;
  localparam int SETS_W   = 2;
  localparam int C_TAPS   = 4;
  localparam int TAPS_W   = 6;
  localparam int C_SYNCSW = 10;
  localparam int C_INIT   = 15;
  localparam int S_GO     = 0;
  // Event bus bits
  localparam int EVT_W    = 3;
  localparam int EV_SWAP  = 0;
  localparam int EV_REJ   = 1;
  localparam int EV_SAT   = 2;
  // Host register offsets
  localparam int HR_W = 3;
  localparam logic [HR_W-1:0] HR_CTRL  = 3'h0;
  localparam logic [HR_W-1:0] HR_SYNC  = 3'h1;
  localparam logic [HR_W-1:0] HR_CADDR = 3'h2;
  localparam logic [HR_W-1:0] HR_CDATA = 3'h3;
  localparam logic [HR_W-1:0] HR_EVT   = 3'h4;

  typedef logic signed [DW-1:0] mlpd_samp_t;
  typedef logic signed [CW-1:0] mlpd_coef_t;
  typedef logic [QW-1:0]        mlpd_qidx_t;
  typedef enum logic {MLPD_ST_CFG = 1'b0, MLPD_ST_RUN = 1'b1} mlpd_state_t;

  // Largest tap count per set for an antenna mode and set count
  function automatic logic [TAPS_W-1:0] mlpd_max_taps(input logic ant4,
                                                      input logic [SETS_W-1:0] sets_m1);
    int base;
    base = ant4 ? TAPS_4ANT : TAPS_2ANT;
    return TAPS_W'(base / (int'(sets_m1) + 1));
  endfunction : mlpd_max_taps
endpackage : mlpd_pkg
`default_nettype wire

/* rtl/mlpd_if.sv */
// Link between the predistortion engine and its host-side partner
`timescale 1ns/1ns
`default_nettype none
interface mlpd_if;
  import mlpd_pkg::*;
  logic                     samp_valid;
  mlpd_samp_t [NUM_ANT-1:0] in_i;
  mlpd_samp_t [NUM_ANT-1:0] in_q;
  logic                     out_valid;
  mlpd_samp_t [NUM_ANT-1:0] out_i;
  mlpd_samp_t [NUM_ANT-1:0] out_q;
  logic                     dl_sync;
  logic                     cfg_wr;
  logic [AW-1:0]            cfg_addr;
  logic [AW-1:0]            cfg_wdata;
  logic [EVT_W-1:0]         evt;

  modport dev (input samp_valid, in_i, in_q, dl_sync, cfg_wr, cfg_addr, cfg_wdata,
               output out_valid, out_i, out_q, evt);
  modport host (output samp_valid, in_i, in_q, dl_sync, cfg_wr, cfg_addr, cfg_wdata,
                input out_valid, out_i, out_q, evt);
endinterface : mlpd_if
`default_nettype wire

/* rtl/mlpd_coef_bank.sv */
// Double-buffered interpolating coefficient tables of one antenna
`timescale 1ns/1ns
`default_nettype none
module mlpd_coef_bank
  import mlpd_pkg::*;
#(
  parameter int N_SLOT = SLOTS
) (
  input  wire logic                    clock_in,
  input  wire logic                    resetn_in,
  input  wire logic                    wr_in,
  input  wire logic [SLOT_W-1:0]       wr_slot_in,
  input  wire logic [IDX_W-1:0]        wr_ent_in,
  input  wire mlpd_coef_t              wr_data_in,
  input  wire logic                    swap_in,
  input  wire mlpd_qidx_t [N_SLOT-1:0] qidx_in,
  output var  mlpd_coef_t [N_SLOT-1:0] coef_out,
  output logic                         bank_out
);
  mlpd_coef_t mem_q [2][N_SLOT][DEPTH];
  logic       act_q;
  logic       wsel;

  // Linear step between two neighbouring entries
  function automatic mlpd_coef_t interp(input mlpd_coef_t c0,
                                        input mlpd_coef_t c1,
                                        input logic [FRAC_W-1:0] fr);
    logic signed [CW:0]          diff;
    logic signed [CW+FRAC_W+1:0] prod;
    diff = $signed({c1[CW-1], c1}) - $signed({c0[CW-1], c0});
    prod = diff * $signed({1'b0, fr});
    return CW'(c0 + CW'(prod >>> FRAC_W));
  endfunction : interp

  for (genvar s = 0; s < N_SLOT; s++) begin : g_rd
    wire logic [IDX_W-1:0] lo = qidx_in[s][QW-1 -: IDX_W];
    wire logic [IDX_W-1:0] hi = (&lo) ? lo : lo + IDX_W'(1);
    assign coef_out[s] = interp(mem_q[act_q][s][lo], mem_q[act_q][s][hi],
                                qidx_in[s][FRAC_W-1:0]);
  end

  // A write in the swap cycle lands in the bank that just went idle
  assign wsel     = swap_in ? act_q : ~act_q;
  assign bank_out = act_q;

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      act_q <= 1'b0;
      for (int b = 0; b < 2; b++)
        for (int s = 0; s < N_SLOT; s++)
          for (int e = 0; e < DEPTH; e++)
            mem_q[b][s][e] <= (s == 0) ? COEF_UNITY : '0;
    end else begin
      if (swap_in)
        act_q <= ~act_q;
      if (wr_in)
        mem_q[wsel][wr_slot_in][wr_ent_in] <= wr_data_in;
    end
  end
endmodule : mlpd_coef_bank
`default_nettype wire

/* rtl/mlpd_engine.sv */
// Predistortion engine end: index, tables, memory taps and bank swap
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Index from magnitude or its square, preset
// - Each stream quantises its magnitude into index
// - Each table gives one tap coefficient
// - Two-antenna and four-antenna modes
// - Two antennas: 36, 18, 12, 9 taps
// - Four antennas: 18, 9, 6, 4 taps
// - One to four sets; taps depend
// - Set uses index plus delayed index chain
// - Coefficients times delayed IQ, accumulated
// - Sum of sets is corrected output
// - Antennas keep fully separate tables
// - Sync from downlink timing or software
// - Host loads tables per antenna stream
// - Loaded tables go active only on sync
// - Two banks, swap on sync
// - Reset tables give unity single-tap pass
// - Host may zero unused taps and sets
// - Host counts match hardware set and tap counts
// - Bypass output is delayed input
// - Upstream peaks near minus six dBFS
// - Four input and four output streams
// - Events reported on event bus
module mlpd_engine
  import mlpd_pkg::*;
#(
  parameter int N_SLOT = SLOTS
) (
  input wire logic clock_in,
  input wire logic resetn_in,
  mlpd_if.dev      link
);
  mlpd_state_t        state_q;
  mlpd_state_t        state_d;
  logic               magsq_q;
  logic               ant4_q;
  logic               syncsw_q;
  logic [SETS_W-1:0]  sets_m1_q;
  logic [TAPS_W-1:0]  taps_q;
  logic [NUM_ANT-1:0] dirty_q;
  logic [NUM_ANT-1:0] dirty_d;
  logic [NUM_ANT-1:0] swap;
  logic [NUM_ANT-1:0] wr_ant;
  logic [NUM_ANT-1:0] sat;
  logic [EVT_W-1:0]   evt_q;
  logic [EVT_W-1:0]   evt_d;
  logic               v1_q;
  logic               ov_q;

  // Quantised index: integer part selects entries, low bits interpolate
  function automatic mlpd_qidx_t quant(input mlpd_samp_t i,
                                       input mlpd_samp_t q,
                                       input logic sq);
    logic signed [2*DW-1:0] ii;
    logic signed [2*DW-1:0] qq;
    logic [2*DW-1:0]        p;
    logic [DW-1:0]          ai;
    logic [DW-1:0]          aq;
    logic [DW-1:0]          mx;
    logic [DW-1:0]          mn;
    logic [DW:0]            m;
    ii = i * i;
    qq = q * q;
    p  = unsigned'(ii) + unsigned'(qq);
    ai = i[DW-1] ? unsigned'(-i) : unsigned'(i);
    aq = q[DW-1] ? unsigned'(-q) : unsigned'(q);
    mx = (ai > aq) ? ai : aq;
    mn = (ai > aq) ? aq : ai;
    m  = {1'b0, mx} + (DW+1)'(mn >> 1);
    return sq ? p[2*DW-1 -: QW] : m[DW -: QW];
  endfunction : quant

  // Slot layout: set k holds taps 0 .. taps-1 in slots k*taps .. k*taps+taps-1
  function automatic int tap_of(input int s, input logic [TAPS_W-1:0] taps);
    return s % int'(taps);
  endfunction : tap_of

  function automatic int set_of(input int s, input logic [TAPS_W-1:0] taps);
    return s / int'(taps);
  endfunction : set_of

  function automatic logic signed [ACC_W-1:0] mul(input mlpd_coef_t c, input mlpd_samp_t x);
    return ACC_W'(c) * ACC_W'(x);
  endfunction : mul

  function automatic mlpd_samp_t clip(input logic signed [ACC_W-1:0] v);
    logic signed [ACC_W-1:0] hi;
    logic signed [ACC_W-1:0] lo;
    hi = ACC_W'({1'b0, {(DW-1){1'b1}}});
    lo = -hi - ACC_W'(1);
    return (v > hi) ? DW'(hi) : (v < lo) ? DW'(lo) : DW'(v);
  endfunction : clip

  // Configuration bus decode
  wire logic              is_coef  = link.cfg_wr & link.cfg_addr[A_COEF];
  wire logic [ANT_W-1:0]  c_ant    = link.cfg_addr[A_ANT +: ANT_W];
  wire logic [SLOT_W-1:0] c_slot   = link.cfg_addr[A_SLOT +: SLOT_W];
  wire logic [ENT_W-1:0]  c_ent    = link.cfg_addr[A_ENT +: ENT_W];
  wire logic              ant_ok   = ant4_q | (int'(c_ant) < ANT_2MODE);
  wire logic              coef_ok  = is_coef & ant_ok & (int'(c_slot) < N_SLOT)
                                     & (int'(c_ent) < DEPTH);
  wire logic              hit_ctrl = link.cfg_wr & (link.cfg_addr == ADDR_CTRL);
  wire logic              hit_sync = link.cfg_wr & (link.cfg_addr == ADDR_SYNC);
  wire logic              ctrl_wr  = hit_ctrl & (state_q == MLPD_ST_CFG);
  wire logic              sw_sync  = hit_sync & link.cfg_wdata[S_GO];
  wire logic              reject   = (is_coef & ~coef_ok) | (hit_ctrl & ~ctrl_wr)
                                     | (link.cfg_wr & ~is_coef & ~hit_ctrl & ~hit_sync);
  wire logic              sync_evt = (state_q == MLPD_ST_RUN)
                                     & (syncsw_q ? sw_sync : link.dl_sync);

  // Tap count held within what the antenna mode and set count allow
  wire logic [SETS_W-1:0] w_sets  = link.cfg_wdata[C_SETS +: SETS_W];
  wire logic [TAPS_W-1:0] w_taps  = link.cfg_wdata[C_TAPS +: TAPS_W];
  wire logic [TAPS_W-1:0] w_max   = mlpd_max_taps(link.cfg_wdata[C_ANT4], w_sets);
  wire logic [TAPS_W-1:0] w_clamp = (w_taps == '0) ? TAPS_W'(1)
                                    : (w_taps > w_max) ? w_max : w_taps;

  assign wr_ant  = coef_ok ? (NUM_ANT'(1) << c_ant) : '0;
  assign swap    = {NUM_ANT{sync_evt}} & dirty_q;
  assign dirty_d = (dirty_q & ~swap) | wr_ant;

  assign evt_d[EV_SWAP] = |swap;
  assign evt_d[EV_REJ]  = reject;
  assign evt_d[EV_SAT]  = |sat;

  always_comb begin
    state_d = state_q;
    case (state_q)
      MLPD_ST_CFG: begin
        if (ctrl_wr && link.cfg_wdata[C_INIT])
          state_d = MLPD_ST_RUN;
      end
      MLPD_ST_RUN: state_d = MLPD_ST_RUN;
      default:     state_d = MLPD_ST_CFG;
    endcase
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q   <= MLPD_ST_CFG;
      magsq_q   <= 1'b0;
      ant4_q    <= RST_ANT4;
      syncsw_q  <= 1'b0;
      sets_m1_q <= '0;
      taps_q    <= TAPS_W'(1);
      dirty_q   <= '0;
      evt_q     <= '0;
      v1_q      <= 1'b0;
      ov_q      <= 1'b0;
    end else begin
      state_q <= state_d;
      if (ctrl_wr) begin
        magsq_q   <= link.cfg_wdata[C_MAGSQ];
        ant4_q    <= link.cfg_wdata[C_ANT4];
        syncsw_q  <= link.cfg_wdata[C_SYNCSW];
        sets_m1_q <= w_sets;
        taps_q    <= w_clamp;
      end
      dirty_q <= dirty_d;
      evt_q   <= evt_d;
      v1_q    <= link.samp_valid;
      ov_q    <= v1_q;
    end
  end

  assign link.evt       = evt_q;
  assign link.out_valid = ov_q;

  for (genvar a = 0; a < NUM_ANT; a++) begin : g_ant
    mlpd_samp_t              i_dl_q [N_SLOT];
    mlpd_samp_t              q_dl_q [N_SLOT];
    mlpd_qidx_t              x_dl_q [N_SLOT];
    mlpd_qidx_t [N_SLOT-1:0] slot_x;
    mlpd_coef_t [N_SLOT-1:0] coef;
    logic signed [ACC_W-1:0] acc_i;
    logic signed [ACC_W-1:0] acc_q;
    logic signed [ACC_W-1:0] sh_i;
    logic signed [ACC_W-1:0] sh_q;
    mlpd_samp_t              o_i_q;
    mlpd_samp_t              o_q_q;
    wire logic               en = ant4_q | (a < ANT_2MODE);

    // Set k reads its index k samples later than its taps' own lag
    for (genvar s = 0; s < N_SLOT; s++) begin : g_slot
      assign slot_x[s] = x_dl_q[tap_of(s, taps_q) + set_of(s, taps_q)];
    end

    mlpd_coef_bank #(
      .N_SLOT (N_SLOT)
    ) u_bank (
      .clock_in   (clock_in),
      .resetn_in  (resetn_in),
      .wr_in      (wr_ant[a]),
      .wr_slot_in (c_slot),
      .wr_ent_in  (c_ent[IDX_W-1:0]),
      .wr_data_in (CW'(link.cfg_wdata)),
      .swap_in    (swap[a]),
      .qidx_in    (slot_x),
      .coef_out   (coef),
      .bank_out   ()
    );

    always_comb begin
      acc_i = '0;
      acc_q = '0;
      for (int s = 0; s < N_SLOT; s++) begin
        if (set_of(s, taps_q) <= int'(sets_m1_q)) begin
          acc_i = acc_i + mul(coef[s], i_dl_q[tap_of(s, taps_q)]);
          acc_q = acc_q + mul(coef[s], q_dl_q[tap_of(s, taps_q)]);
        end
      end
    end

    assign sh_i   = acc_i >>> COEF_FRAC;
    assign sh_q   = acc_q >>> COEF_FRAC;
    assign sat[a] = v1_q & en & ((ACC_W'(clip(sh_i)) != sh_i) | (ACC_W'(clip(sh_q)) != sh_q));

    always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
        for (int s = 0; s < N_SLOT; s++) begin
          i_dl_q[s] <= '0;
          q_dl_q[s] <= '0;
          x_dl_q[s] <= '0;
        end
        o_i_q <= '0;
        o_q_q <= '0;
      end else begin
        if (link.samp_valid && en) begin
          i_dl_q[0] <= link.in_i[a];
          q_dl_q[0] <= link.in_q[a];
          x_dl_q[0] <= quant(link.in_i[a], link.in_q[a], magsq_q);
          for (int s = 1; s < N_SLOT; s++) begin
            i_dl_q[s] <= i_dl_q[s-1];
            q_dl_q[s] <= q_dl_q[s-1];
            x_dl_q[s] <= x_dl_q[s-1];
          end
        end
        if (v1_q) begin
          o_i_q <= en ? clip(sh_i) : '0;
          o_q_q <= en ? clip(sh_q) : '0;
        end
      end
    end

    assign link.out_i[a] = o_i_q;
    assign link.out_q[a] = o_q_q;
  end
endmodule : mlpd_engine
`default_nettype wire

/* rtl/mlpd_host.sv */
// Host-side partner: sample source and sink, configuration bridge
`timescale 1ns/1ns
`default_nettype none
module mlpd_host
  import mlpd_pkg::*;
(
  input  wire logic                     clock_in,
  input  wire logic                     resetn_in,
  mlpd_if.host                          link,
  input  wire logic [HR_W-1:0]          sw_addr_in,
  input  wire logic [AW-1:0]            sw_wdata_in,
  input  wire logic                     sw_wr_in,
  input  wire logic                     sw_rd_in,
  output logic [AW-1:0]                 sw_rdata_out,
  input  wire logic                     src_valid_in,
  input  wire mlpd_samp_t [NUM_ANT-1:0] src_i_in,
  input  wire mlpd_samp_t [NUM_ANT-1:0] src_q_in,
  input  wire logic                     dl_sync_pin_in,
  output logic                          snk_valid_out,
  output var  mlpd_samp_t [NUM_ANT-1:0] snk_i_out,
  output var  mlpd_samp_t [NUM_ANT-1:0] snk_q_out
);
  logic                     sv_q;
  mlpd_samp_t [NUM_ANT-1:0] si_q;
  mlpd_samp_t [NUM_ANT-1:0] sq_q;
  logic                     ov_q;
  mlpd_samp_t [NUM_ANT-1:0] oi_q;
  mlpd_samp_t [NUM_ANT-1:0] oq_q;
  logic                     sy1_q;
  logic                     sy2_q;
  logic                     sy3_q;
  logic                     dls_q;
  logic                     cwr_q;
  logic [AW-1:0]            cadr_q;
  logic [AW-1:0]            cdat_q;
  logic [AW-1:0]            ctrl_q;
  logic [AW-1:0]            caddr_q;
  logic [EVT_W-1:0]         evt_q;
  logic [AW-1:0]            rdata_q;

  wire logic wr_ctrl  = sw_wr_in & (sw_addr_in == HR_CTRL);
  wire logic wr_sync  = sw_wr_in & (sw_addr_in == HR_SYNC);
  wire logic wr_caddr = sw_wr_in & (sw_addr_in == HR_CADDR);
  wire logic wr_cdata = sw_wr_in & (sw_addr_in == HR_CDATA);
  wire logic wr_evt   = sw_wr_in & (sw_addr_in == HR_EVT);
  wire logic fwd      = wr_ctrl | wr_sync | wr_cdata;

  // Table writes carry the antenna, slot and entry held in the address register
  wire logic [AW-1:0] coef_adr = caddr_q | (AW'(1) << A_COEF);
  wire logic [AW-1:0] cadr_d   = wr_ctrl ? ADDR_CTRL : wr_sync ? ADDR_SYNC : coef_adr;
  wire logic [EVT_W-1:0] clr   = wr_evt ? sw_wdata_in[EVT_W-1:0] : '0;
  wire logic [EVT_W-1:0] evt_d = (evt_q & ~clr) | link.evt;
  wire logic [AW-1:0] rd_mux   = (sw_addr_in == HR_CTRL)  ? ctrl_q
                               : (sw_addr_in == HR_CADDR) ? caddr_q
                               : (sw_addr_in == HR_EVT)   ? AW'(evt_q) : '0;

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sv_q    <= 1'b0;
      si_q    <= '0;
      sq_q    <= '0;
      ov_q    <= 1'b0;
      oi_q    <= '0;
      oq_q    <= '0;
      sy1_q   <= 1'b0;
      sy2_q   <= 1'b0;
      sy3_q   <= 1'b0;
      dls_q   <= 1'b0;
      cwr_q   <= 1'b0;
      cadr_q  <= '0;
      cdat_q  <= '0;
      ctrl_q  <= '0;
      caddr_q <= '0;
      evt_q   <= '0;
      rdata_q <= '0;
    end else begin
      sv_q  <= src_valid_in;
      si_q  <= src_i_in;
      sq_q  <= src_q_in;
      ov_q  <= link.out_valid;
      oi_q  <= link.out_i;
      oq_q  <= link.out_q;
      sy1_q <= dl_sync_pin_in;
      sy2_q <= sy1_q;
      sy3_q <= sy2_q;
      dls_q <= sy2_q & ~sy3_q;
      cwr_q <= fwd;
      if (fwd) begin
        cadr_q <= cadr_d;
        cdat_q <= sw_wdata_in;
      end
      if (wr_ctrl)
        ctrl_q <= sw_wdata_in;
      if (wr_caddr)
        caddr_q <= sw_wdata_in;
      evt_q <= evt_d;
      if (sw_rd_in)
        rdata_q <= rd_mux;
    end
  end

  assign link.samp_valid = sv_q;
  assign link.in_i       = si_q;
  assign link.in_q       = sq_q;
  assign link.dl_sync    = dls_q;
  assign link.cfg_wr     = cwr_q;
  assign link.cfg_addr   = cadr_q;
  assign link.cfg_wdata  = cdat_q;
  assign sw_rdata_out    = rdata_q;
  assign snk_valid_out   = ov_q;
  assign snk_i_out       = oi_q;
  assign snk_q_out       = oq_q;
endmodule : mlpd_host
`default_nettype wire

/* test/mlpd_checker.sv */
// Concurrent checks on the link between the engine and the host end
`timescale 1ns/1ns
`default_nettype none
module mlpd_checker
  import mlpd_pkg::*;
(
  input wire logic                     clock_in,
  input wire logic                     resetn_in,
  input wire logic                     samp_valid,
  input wire mlpd_samp_t [NUM_ANT-1:0] in_i,
  input wire mlpd_samp_t [NUM_ANT-1:0] in_q,
  input wire logic                     out_valid,
  input wire mlpd_samp_t [NUM_ANT-1:0] out_i,
  input wire mlpd_samp_t [NUM_ANT-1:0] out_q,
  input wire logic                     dl_sync,
  input wire logic                     cfg_wr,
  input wire logic [AW-1:0]            cfg_addr,
  input wire logic [AW-1:0]            cfg_wdata,
  input wire logic [EVT_W-1:0]         evt
);
  logic locked_q;
  logic ant4_q;
  logic bypass_q;
  wire logic ctrl_wr = cfg_wr && (cfg_addr == ADDR_CTRL);
  wire logic sync_ev = dl_sync || (cfg_wr && cfg_addr == ADDR_SYNC && cfg_wdata[S_GO]);
  wire logic coef_wr = cfg_wr && cfg_addr[A_COEF];
  wire logic coef_bad = coef_wr && (cfg_addr[A_SLOT +: SLOT_W] >= SLOT_W'(SLOTS)
                        || cfg_addr[A_ENT +: ENT_W] >= ENT_W'(DEPTH)
                        || (!ant4_q && cfg_addr[A_ANT+1]));

  // Tracks lock, antenna mode and whether any sync may have swapped tables
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      locked_q <= 1'b0;
      ant4_q   <= RST_ANT4;
      bypass_q <= 1'b1;
    end else begin
      if (ctrl_wr && !locked_q) begin
        locked_q <= cfg_wdata[C_INIT];
        ant4_q   <= cfg_wdata[C_ANT4];
      end
      if (sync_ev) begin
        bypass_q <= 1'b0;
      end
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!resetn_in);

  a_out_latency: assert property (samp_valid |-> ##2 out_valid)
    else $error("output strobe missing two cycles after a sample");
  a_out_hold: assert property (!out_valid |-> $stable(out_i) && $stable(out_q))
    else $error("output changed without a strobe");
  a_bypass_pass: assert property (bypass_q && out_valid |->
    out_i[0] == $past(in_i[0], 2) && out_q[1] == $past(in_q[1], 2))
    else $error("reset tables do not pass the input through");
  a_swap_cause: assert property (evt[EV_SWAP] |-> locked_q && $past(sync_ev))
    else $error("bank swap without a sync while running");
  a_reject_cause: assert property (evt[EV_REJ] |-> $past(cfg_wr))
    else $error("reject event without a write");
  a_relock_reject: assert property (ctrl_wr && locked_q |=> evt[EV_REJ])
    else $error("control write after init not rejected");
  a_coef_reject: assert property (coef_bad |=> evt[EV_REJ])
    else $error("illegal table write not rejected");
  a_coef_accept: assert property (coef_wr && !coef_bad |=> !evt[EV_REJ])
    else $error("legal table write rejected");
endmodule : mlpd_checker
`default_nettype wire

/* test/tb_memory_lut_predistorter.sv */
// Self-checking bench joining the engine and host ends
`timescale 1ns/1ns
`default_nettype none
module tb_memory_lut_predistorter;
  import mlpd_pkg::*;
  logic                     clock_in = 1'b0;
  logic                     resetn_in = 1'b0;
  logic [HR_W-1:0]          sw_addr_in = '0;
  logic [AW-1:0]            sw_wdata_in = '0;
  logic                     sw_wr_in = 1'b0;
  logic                     sw_rd_in = 1'b0;
  logic [AW-1:0]            sw_rdata_out;
  logic                     src_valid_in = 1'b0;
  mlpd_samp_t [NUM_ANT-1:0] src_i_in = '0;
  mlpd_samp_t [NUM_ANT-1:0] src_q_in = '0;
  logic                     dl_sync_pin_in = 1'b0;
  logic                     snk_valid_out;
  mlpd_samp_t [NUM_ANT-1:0] snk_i_out;
  mlpd_samp_t [NUM_ANT-1:0] snk_q_out;
  mlpd_samp_t [NUM_ANT-1:0] qi[$];
  mlpd_samp_t [NUM_ANT-1:0] qq[$];
  int                       err_total = 0;
  int                       n_tests = 0;
  int                       c0[NUM_ANT];
  int                       c1[NUM_ANT];
  int                       en[NUM_ANT];
  int                       pi[NUM_ANT];
  int                       pq[NUM_ANT];
  logic [AW-1:0]            rdv;

  always #2 clock_in = ~clock_in;

  mlpd_if link ();
  mlpd_engine mlpd_engine_i (.clock_in(clock_in), .resetn_in(resetn_in), .link(link));
  mlpd_host mlpd_host_i (.clock_in(clock_in), .resetn_in(resetn_in), .link(link),
    .sw_addr_in(sw_addr_in), .sw_wdata_in(sw_wdata_in), .sw_wr_in(sw_wr_in),
    .sw_rd_in(sw_rd_in), .sw_rdata_out(sw_rdata_out), .src_valid_in(src_valid_in),
    .src_i_in(src_i_in), .src_q_in(src_q_in), .dl_sync_pin_in(dl_sync_pin_in),
    .snk_valid_out(snk_valid_out), .snk_i_out(snk_i_out), .snk_q_out(snk_q_out));
  mlpd_checker mlpd_checker_i (.clock_in(clock_in), .resetn_in(resetn_in),
    .samp_valid(link.samp_valid), .in_i(link.in_i), .in_q(link.in_q),
    .out_valid(link.out_valid), .out_i(link.out_i), .out_q(link.out_q),
    .dl_sync(link.dl_sync), .cfg_wr(link.cfg_wr), .cfg_addr(link.cfg_addr),
    .cfg_wdata(link.cfg_wdata), .evt(link.evt));

  task automatic chk(input string nm, input logic [AW-1:0] e, input logic [AW-1:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic tally_and_finish();
    $display("Comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [HR_W-1:0] a, input logic [AW-1:0] d);
    @(posedge clock_in);
    sw_addr_in  <= a;
    sw_wdata_in <= d;
    sw_wr_in    <= 1'b1;
    @(posedge clock_in);
    sw_wr_in <= 1'b0;
  endtask : wr

  task automatic rd(input logic [HR_W-1:0] a);
    @(posedge clock_in);
    sw_addr_in <= a;
    sw_rd_in   <= 1'b1;
    @(posedge clock_in);
    sw_rd_in <= 1'b0;
    @(posedge clock_in);
    rdv = sw_rdata_out;
  endtask : rd

  // Polls the sticky event register under a bounded count
  task automatic wait_evt(input int b);
    int k;
    k   = 0;
    rdv = '0;
    while (rdv[b] !== 1'b1 && k < 40) begin
      rd(HR_EVT);
      k++;
    end
    chk("event bit", 16'h0001, AW'(rdv[b]));
    if (rdv[b] !== 1'b1)
      tally_and_finish();
  endtask : wait_evt

  task automatic coef(input int a, input int s, input logic [AW-1:0] v);
    for (int e = 0; e < DEPTH; e++) begin
      wr(HR_CADDR, AW'((a << A_ANT) | (s << A_SLOT) | e));
      wr(HR_CDATA, v);
    end
  endtask : coef

  task automatic mreset();
    resetn_in <= 1'b0;
    for (int a = 0; a < NUM_ANT; a++) begin
      c0[a] = 16384;
      c1[a] = 0;
      en[a] = 1;
      pi[a] = 0;
      pq[a] = 0;
    end
    qi.delete();
    qq.delete();
    repeat (12) @(posedge clock_in);
    resetn_in <= 1'b1;
  endtask : mreset

  // Random samples in range; expected output is the two-tap product sum of the model
  task automatic stream(input int n);
    int                       x;
    int                       y;
    mlpd_samp_t [NUM_ANT-1:0] ei;
    mlpd_samp_t [NUM_ANT-1:0] eq;
    repeat (n) begin
      @(posedge clock_in);
      for (int a = 0; a < NUM_ANT; a++) begin
        x = int'($urandom_range(32000)) - 16000;
        y = int'($urandom_range(32000)) - 16000;
        src_i_in[a] <= mlpd_samp_t'(x);
        src_q_in[a] <= mlpd_samp_t'(y);
        ei[a] = mlpd_samp_t'(en[a] * ((x * c0[a] + pi[a] * c1[a]) >>> 14));
        eq[a] = mlpd_samp_t'(en[a] * ((y * c0[a] + pq[a] * c1[a]) >>> 14));
        pi[a] = x;
        pq[a] = y;
      end
      src_valid_in <= 1'b1;
      qi.push_back(ei);
      qq.push_back(eq);
    end
    @(posedge clock_in);
    src_valid_in <= 1'b0;
    repeat (10) @(posedge clock_in);
    chk("drain", '0, AW'(qi.size()));
  endtask : stream

  always @(posedge clock_in) begin
    if (resetn_in && snk_valid_out === 1'b1) begin
      if (qi.size() == 0)
        chk("spare output", '0, 16'h0001);
      else begin
        for (int a = 0; a < NUM_ANT; a++) begin
          chk("out i", qi[0][a], snk_i_out[a]);
          chk("out q", qq[0][a], snk_q_out[a]);
        end
        void'(qi.pop_front());
        void'(qq.pop_front());
      end
    end
  end

  initial begin
    #400000;
    chk("watchdog", '0, 16'h0001);
    tally_and_finish();
  end

  initial begin
    void'($urandom(40931));
    mreset();
    stream(24);
    rd(3'h5);
    chk("unmapped read", '0, rdv);
    // Four antennas, one tap, downlink sync; load antenna 1 while streaming
    wr(HR_CTRL, 16'h8012);
    wr(HR_EVT, 16'h0007);
    fork
      stream(20);
      coef(1, 0, 16'h2000);
    join
    stream(8);
    dl_sync_pin_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    dl_sync_pin_in <= 1'b0;
    wait_evt(EV_SWAP);
    c0[1] = 8192;
    stream(24);
    // Two antennas, two taps, software sync, after a second reset
    mreset();
    wr(HR_CTRL, 16'h8421);
    en[2] = 0;
    en[3] = 0;
    wr(HR_CTRL, 16'h0003);
    coef(2, 0, 16'h4000);
    wr(HR_CADDR, 16'h0A00);
    wr(HR_CDATA, 16'h1111);
    wait_evt(EV_REJ);
    coef(0, 0, 16'hC000);
    coef(0, 1, 16'h2000);
    coef(1, 0, 16'h2000);
    coef(1, 1, 16'h0000);
    stream(12);
    wr(HR_SYNC, 16'h0001);
    wait_evt(EV_SWAP);
    c0[0] = -16384;
    c1[0] = 8192;
    c0[1] = 8192;
    stream(30);
    tally_and_finish();
  end
endmodule : tb_memory_lut_predistorter
`default_nettype wire
